//--- pkg/hsc_regs.svh
// Offsets, field positions, reset values and timing counts of the standby control
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH

// Register byte offsets, one aligned 32-bit word each
`define HSC_LSR_MODE_OFS 4'h0
`define HSC_CONFIG_OFS 4'h4
`define HSC_STATUS_OFS 4'h8

// Low-speed oscillator mode register fields
`define HSC_LSR_STOP_BIT 0
`define HSC_LSR_MODE_RST 1'h0

// Configuration register fields
`define HSC_CFG_STOPPABLE_BIT 0
`define HSC_CFG_WDT_LS_BIT 1
`define HSC_CFG_TMR_LS_BIT 2
`define HSC_CFG_STOPPABLE_RST 1'h0
`define HSC_CFG_WDT_LS_RST 1'h1
`define HSC_CFG_TMR_LS_RST 1'h0

// Status register fields
`define HSC_STS_HALTED_BIT 0
`define HSC_STS_OPT_WAIT_BIT 1
`define HSC_STS_WAKING_BIT 2
`define HSC_STS_LS_RUN_BIT 3
`define HSC_STS_CPU_CLK_BIT 4

// Timing
`define HSC_CLK_PERIOD_NS 5
`define HSC_OPT_REF_TYP_NS 544000
`define HSC_WAKE_VEC_CLKS 12
`define HSC_WAKE_NEXT_CLKS 4

`endif

//--- pkg/hsc_pkg.sv
// Types shared by the standby control
package hsc_pkg;

    localparam int HSC_CNT_W = 24;

    typedef enum logic [2:0] {
        ST_OPT_WAIT,
        ST_RUN,
        ST_HALT,
        ST_WAKE_VEC,
        ST_WAKE_NEXT
    } hsc_state_type;

    typedef logic [HSC_CNT_W-1:0] hsc_cnt_type;
    typedef logic [31:0] hsc_word_type;

    typedef struct packed {
        hsc_state_type state;
        hsc_cnt_type cnt;
        logic cpu_clk_en;
        logic vec_start;
        logic next_start;
        logic rst_vec_start;
        logic lsr_stop;
        logic cfg_stoppable;
        logic cfg_wdt_ls;
        logic cfg_tmr_ls;
        logic ack;
        hsc_word_type rdata;
    } hsc_ctx_type;

endpackage

//--- verilog/hsc_top.sv
// Light sleep (halt) standby control with Avalon-MM register access
//
// How it works
// R01: Sleep instruction puts the device into halt.
// R02: Pending unmasked request cancels halt at once.
// R03: Processor clock gated; system clock keeps running.
// R04: Port output latches hold their pre-halt value.
// R05: Timers, converter, serial, detector keep running.
// R06: Second timer stops only with stopped oscillator.
// R07: System-clocked watchdog stops in halt.
// R08: Only unmasked requests wake; mask one stays asleep.
// R09: Wake with accept flag set: vectored servicing.
// R10: Wake with accept flag clear: next instruction.
// R11: Vectored wake takes 11 to 13 clocks.
// R12: Non-vectored wake takes 3 to 5 clocks.
// R13: Reset leaves halt via normal reset sequence.
// R14: Processor held during option byte reference delay.
// R15: Accept flag clear blocks servicing of requests.
// R16: Registers, memory and ports kept across standby.
// R17: Stop bit halts low-speed oscillator when permitted.
// R18: Wake delay counted in system clocks, synchronous.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "hsc_regs.svh"

module hsc_top #(
    parameter int NUM_IRQ = 8,
    parameter int OPT_REF_CYC = `HSC_OPT_REF_TYP_NS / `HSC_CLK_PERIOD_NS
) (
    input wire logic clock,
    input wire logic rst_b,
    // Processor side
    input wire logic halt_exec,
    output logic cpu_clk_en,
    output logic vector_start,
    output logic next_instr_start,
    output logic reset_vector_start,
    output logic port_latch_hold,
    // Interrupt logic side
    input wire logic [NUM_IRQ-1:0] irq_request_flag,
    input wire logic [NUM_IRQ-1:0] interrupt_mask_flag,
    input wire logic global_interrupt_accept_flag,
    // Clock and peripheral run controls
    output logic periph_clk_en,
    output logic low_speed_osc_run,
    output logic second_8bit_timer_run,
    output logic watchdog_run,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output hsc_pkg::hsc_word_type avs_readdata,
    output logic avs_waitrequest
);
    import hsc_pkg::*;

    localparam hsc_cnt_type OPT_LOAD = hsc_cnt_type'(OPT_REF_CYC - 1);
    localparam hsc_cnt_type VEC_LOAD = hsc_cnt_type'(`HSC_WAKE_VEC_CLKS - 2);
    localparam hsc_cnt_type NEXT_LOAD = hsc_cnt_type'(`HSC_WAKE_NEXT_CLKS - 2);

    // Refused at elaboration: the pending mask and delay counter cannot serve these
    if (NUM_IRQ < 1 || NUM_IRQ > 64) begin : g_bad_num_irq
        $error("NUM_IRQ must lie in 1..64");
    end
    if (OPT_REF_CYC < 1 || OPT_REF_CYC >= (1 << HSC_CNT_W)) begin : g_bad_opt_ref
        $error("OPT_REF_CYC does not fit the delay counter");
    end

    hsc_ctx_type ctx_ff;
    hsc_ctx_type nxt_ctx;

    logic pend;
    logic ls_osc_on;
    logic bus_req;
    logic bus_done;
    logic halted;

    // Request flag set with mask flag clear, accept flag ignored
    function automatic logic irq_pending(
        input logic [NUM_IRQ-1:0] req,
        input logic [NUM_IRQ-1:0] mask
    );
        irq_pending = |(req & ~mask);
    endfunction

    // Start of a wake sequence: servicing only when acceptance enabled
    function automatic hsc_ctx_type start_wake(
        input hsc_ctx_type cur,
        input logic accept
    );
        hsc_ctx_type res;
        res = cur;
        res.cpu_clk_en = 1'h0;
        if (accept) begin
            res.state = ST_WAKE_VEC; // see R09
            res.cnt = VEC_LOAD; // see R11
        end else begin
            res.state = ST_WAKE_NEXT; // see R10 see R15
            res.cnt = NEXT_LOAD; // see R12
        end
        start_wake = res;
    endfunction

    assign pend = irq_pending(irq_request_flag, interrupt_mask_flag); // see R08
    assign halted = (ctx_ff.state == ST_HALT);

    // Stop bit only counts when the option allows software stopping
    assign ls_osc_on = ~(ctx_ff.cfg_stoppable & ctx_ff.lsr_stop); // see R17

    assign bus_req = avs_read | avs_write;
    assign bus_done = bus_req & ctx_ff.ack;

    // One wait state: readdata is captured before waitrequest falls
    assign avs_waitrequest = bus_req & ~ctx_ff.ack;
    assign avs_readdata = ctx_ff.rdata;

    always_comb begin
        nxt_ctx = ctx_ff;
        nxt_ctx.vec_start = 1'h0;
        nxt_ctx.next_start = 1'h0;
        nxt_ctx.rst_vec_start = 1'h0;

        // Sequencer
        unique case (ctx_ff.state)
            ST_OPT_WAIT: begin
                // Processor held while the option byte is referenced
                if (ctx_ff.cnt == '0) begin // see R14
                    nxt_ctx.state = ST_RUN;
                    nxt_ctx.cpu_clk_en = 1'h1;
                    nxt_ctx.rst_vec_start = 1'h1; // see R13
                end else begin
                    nxt_ctx.cnt = ctx_ff.cnt - hsc_cnt_type'(1);
                end
            end
            ST_RUN: begin
                if (halt_exec) begin
                    if (pend) begin
                        // Halt would be cleared at once, so skip it
                        nxt_ctx = start_wake(ctx_ff, global_interrupt_accept_flag); // see R02
                    end else begin
                        nxt_ctx.state = ST_HALT; // see R01
                        nxt_ctx.cpu_clk_en = 1'h0; // see R03
                    end
                end
            end
            ST_HALT: begin
                // Masked requests leave the device asleep
                if (pend) begin // see R08
                    nxt_ctx = start_wake(ctx_ff, global_interrupt_accept_flag);
                end
            end
            ST_WAKE_VEC: begin
                if (ctx_ff.cnt == '0) begin
                    nxt_ctx.state = ST_RUN;
                    nxt_ctx.cpu_clk_en = 1'h1; // see R18
                    nxt_ctx.vec_start = 1'h1; // see R09 see R11
                end else begin
                    nxt_ctx.cnt = ctx_ff.cnt - hsc_cnt_type'(1); // see R18
                end
            end
            ST_WAKE_NEXT: begin
                if (ctx_ff.cnt == '0) begin
                    nxt_ctx.state = ST_RUN;
                    nxt_ctx.cpu_clk_en = 1'h1; // see R18
                    nxt_ctx.next_start = 1'h1; // see R10 see R12
                end else begin
                    nxt_ctx.cnt = ctx_ff.cnt - hsc_cnt_type'(1); // see R18
                end
            end
            default: begin
                nxt_ctx.state = ST_RUN;
                nxt_ctx.cpu_clk_en = 1'h1;
            end
        endcase

        // Bus handshake
        nxt_ctx.ack = bus_req & ~ctx_ff.ack;

        // Read capture in the wait cycle
        if (avs_read & ~ctx_ff.ack) begin
            nxt_ctx.rdata = '0;
            unique case (avs_address)
                `HSC_LSR_MODE_OFS: begin
                    nxt_ctx.rdata[`HSC_LSR_STOP_BIT] = ctx_ff.lsr_stop;
                end
                `HSC_CONFIG_OFS: begin
                    nxt_ctx.rdata[`HSC_CFG_STOPPABLE_BIT] = ctx_ff.cfg_stoppable;
                    nxt_ctx.rdata[`HSC_CFG_WDT_LS_BIT] = ctx_ff.cfg_wdt_ls;
                    nxt_ctx.rdata[`HSC_CFG_TMR_LS_BIT] = ctx_ff.cfg_tmr_ls;
                end
                `HSC_STATUS_OFS: begin
                    nxt_ctx.rdata[`HSC_STS_HALTED_BIT] = halted;
                    nxt_ctx.rdata[`HSC_STS_OPT_WAIT_BIT] = (ctx_ff.state == ST_OPT_WAIT);
                    nxt_ctx.rdata[`HSC_STS_WAKING_BIT] = (ctx_ff.state == ST_WAKE_VEC) |
                        (ctx_ff.state == ST_WAKE_NEXT);
                    nxt_ctx.rdata[`HSC_STS_LS_RUN_BIT] = ls_osc_on;
                    nxt_ctx.rdata[`HSC_STS_CPU_CLK_BIT] = ctx_ff.cpu_clk_en;
                end
                default: begin
                    // Unmapped offsets read as zero
                    nxt_ctx.rdata = '0;
                end
            endcase
        end

        // Writes take effect on the edge where waitrequest is low
        if (avs_write & bus_done & avs_byteenable[0]) begin
            unique case (avs_address)
                `HSC_LSR_MODE_OFS: begin
                    nxt_ctx.lsr_stop = avs_writedata[`HSC_LSR_STOP_BIT]; // see R17
                end
                `HSC_CONFIG_OFS: begin
                    nxt_ctx.cfg_stoppable = avs_writedata[`HSC_CFG_STOPPABLE_BIT];
                    nxt_ctx.cfg_tmr_ls = avs_writedata[`HSC_CFG_TMR_LS_BIT];
                    // System clock for the watchdog is refused when the
                    // oscillator cannot be stopped; it would freeze in halt
                    nxt_ctx.cfg_wdt_ls = avs_writedata[`HSC_CFG_WDT_LS_BIT] |
                        ~avs_writedata[`HSC_CFG_STOPPABLE_BIT]; // see R07
                end
                default: begin
                    // Status and unmapped offsets ignore writes
                    nxt_ctx.lsr_stop = ctx_ff.lsr_stop;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            // Reset also releases halt into the normal start-up path
            ctx_ff.state <= ST_OPT_WAIT; // see R13
            ctx_ff.cnt <= OPT_LOAD; // see R14
            ctx_ff.cpu_clk_en <= 1'h0;
            ctx_ff.vec_start <= 1'h0;
            ctx_ff.next_start <= 1'h0;
            ctx_ff.rst_vec_start <= 1'h0;
            ctx_ff.lsr_stop <= `HSC_LSR_MODE_RST;
            ctx_ff.cfg_stoppable <= `HSC_CFG_STOPPABLE_RST;
            ctx_ff.cfg_wdt_ls <= `HSC_CFG_WDT_LS_RST;
            ctx_ff.cfg_tmr_ls <= `HSC_CFG_TMR_LS_RST;
            ctx_ff.ack <= 1'h0;
            ctx_ff.rdata <= '0;
        end else begin
            ctx_ff <= nxt_ctx;
        end
    end

    // Outputs
    assign cpu_clk_en = ctx_ff.cpu_clk_en; // see R03 see R18
    assign vector_start = ctx_ff.vec_start;
    assign next_instr_start = ctx_ff.next_start;
    assign reset_vector_start = ctx_ff.rst_vec_start;

    // Gating only the processor clock leaves all state untouched
    assign port_latch_hold = ~ctx_ff.cpu_clk_en; // see R04 see R16

    // Peripherals see a clock except while reset start-up holds them
    assign periph_clk_en = (ctx_ff.state != ST_OPT_WAIT); // see R05

    assign low_speed_osc_run = ls_osc_on; // see R17

    // Peripheral-clocked timer always runs; low-speed source needs oscillator
    assign second_8bit_timer_run = ~ctx_ff.cfg_tmr_ls | ls_osc_on; // see R06

    // Low-speed clocked watchdog runs while the oscillator runs; system-clocked one stops in halt
    assign watchdog_run = ctx_ff.cfg_wdt_ls ? ls_osc_on : ~halted; // see R07

endmodule // hsc_top

//--- bench/hsc_top_assertions.sv
// Concurrent checks on the standby control ports
`timescale 1ns/10ps
module hsc_top_chk #(
    parameter int NUM_IRQ = 8,
    parameter int OPT_REF_CYC = 20
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic halt_exec,
    input wire logic cpu_clk_en,
    input wire logic vector_start,
    input wire logic next_instr_start,
    input wire logic reset_vector_start,
    input wire logic port_latch_hold,
    input wire logic [NUM_IRQ-1:0] irq_request_flag,
    input wire logic [NUM_IRQ-1:0] interrupt_mask_flag,
    input wire logic global_interrupt_accept_flag,
    input wire logic periph_clk_en,
    input wire logic low_speed_osc_run,
    input wire logic second_8bit_timer_run
);
    logic halted_ff, waking_ff;
    int since_ff;
    wire pend = |(irq_request_flag & ~interrupt_mask_flag);
    // Wake starts once: at the sleep instruction or first pending cycle in halt
    wire start = pend && ((halt_exec && cpu_clk_en) || (halted_ff && !waking_ff));
    wire done = vector_start || next_instr_start;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            halted_ff <= 1'h0;
            waking_ff <= 1'h0;
            since_ff <= 0;
        end else begin
            halted_ff <= !done && (halted_ff || (halt_exec && cpu_clk_en));
            waking_ff <= !done && (waking_ff || start);
            since_ff <= (since_ff < 100000) ? since_ff + 1 : since_ff;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_wake_vec; start && global_interrupt_accept_flag; endsequence
    sequence s_wake_next; start && !global_interrupt_accept_flag; endsequence
    sequence s_quiet; (!cpu_clk_en && !vector_start && !next_instr_start) [*3]; endsequence
    chk_halt_gate: assert property (halt_exec && cpu_clk_en |=> !cpu_clk_en)
        else $error("cpu clock not gated after sleep");
    chk_latch_hold: assert property (port_latch_hold == !cpu_clk_en)
        else $error("port hold disagrees with cpu clock");
    chk_vec_wake: assert property (s_wake_vec |-> ##12 (vector_start && cpu_clk_en))
        else $error("vectored wake not after 12 clocks");
    chk_next_wake: assert property (s_wake_next |-> ##4 (next_instr_start && !vector_start))
        else $error("plain wake not after 4 clocks");
    chk_wake_quiet: assert property (start |=> s_quiet)
        else $error("wake ended early");
    chk_masked_stay: assert property (halted_ff && !waking_ff && !pend |=> !cpu_clk_en)
        else $error("woke without unmasked request");
    chk_timer_run: assert property (low_speed_osc_run |-> second_8bit_timer_run)
        else $error("second timer stopped with oscillator running");
    chk_periph_run: assert property (halted_ff |-> periph_clk_en)
        else $error("peripheral clock stopped in halt");
    chk_optbyte_wait: assert property (since_ff < OPT_REF_CYC |-> !cpu_clk_en)
        else $error("cpu ran during start-up delay");
    chk_rst_vector: assert property (reset_vector_start |-> cpu_clk_en && since_ff >= OPT_REF_CYC)
        else $error("reset vector start early");
endmodule // hsc_top_chk

bind hsc_top hsc_top_chk #(.NUM_IRQ(NUM_IRQ), .OPT_REF_CYC(OPT_REF_CYC)) hsc_top_chk_inst (.*);

//--- bench/hsc_irq_model.sv
// Interrupt request source facing the standby control
`timescale 1ns/10ps
module hsc_irq_model #(
    parameter int NUM_IRQ = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic raise,
    input wire logic clear,
    input wire logic [7:0] line_sel,
    input wire logic vector_start,
    output logic [NUM_IRQ-1:0] irq_request_flag
);
    // Flag stays up until serviced or cleared; an unserviced wake leaves it pending
    always_ff @(posedge clock) begin
        if (!rst_b || clear || vector_start) begin
            irq_request_flag <= {NUM_IRQ{1'h0}};
        end else if (raise) begin
            irq_request_flag[line_sel] <= 1'h1;
        end
    end
endmodule // hsc_irq_model

//--- bench/tb_halt_standby_control.sv
// Self-checking bench for the halt standby control
`timescale 1ns/10ps
module tb_halt_standby_control;
    import hsc_pkg::*;
    localparam int OPT = 20;
    logic clock = 1'h0, rst_b = 1'h0, halt_exec = 1'h0, raise = 1'h0, clear = 1'h0;
    logic avs_read = 1'h0, avs_write = 1'h0, global_interrupt_accept_flag = 1'h0;
    logic [7:0] interrupt_mask_flag = 8'h00, line_sel = 8'h00, irq_request_flag;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    logic [31:0] avs_writedata = 32'h0, seed = 32'h3695;
    hsc_word_type avs_readdata, rdata;
    logic cpu_clk_en, vector_start, next_instr_start, reset_vector_start, port_latch_hold;
    logic periph_clk_en, low_speed_osc_run, second_8bit_timer_run, watchdog_run, avs_waitrequest;
    int fail_count = 0, cmp_count = 0, e_cfg = 2, e_stop = 0;
    always #2.5 clock = ~clock;
    hsc_top #(.NUM_IRQ(8), .OPT_REF_CYC(OPT)) hsc_top_inst (.*);
    hsc_irq_model #(.NUM_IRQ(8)) hsc_irq_model_inst (.*);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic lso_e();
        return !((e_cfg & 1) != 0 && e_stop != 0);
    endfunction
    function automatic logic [31:0] model(input logic [3:0] a);
        case (a)
            4'h0: return 32'(e_stop);
            4'h4: return 32'(e_cfg);
            4'h8: return {27'h0, 1'h1, lso_e(), 3'h0};
            default: return 32'h0;
        endcase
    endfunction
    function automatic logic ev(input int k);
        case (k)
            0: return avs_waitrequest === 1'h0;
            1: return (vector_start | next_instr_start) === 1'h1;
            2: return reset_vector_start === 1'h1;
            default: return |(irq_request_flag & ~interrupt_mask_flag) === 1'h1;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            fail_count++;
        end
    endtask
    task automatic results();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_ev(input int k, output int n);
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (!ev(k) && n < 400);
        if (n >= 400) begin
            fail_count++;
            results();
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clock);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        wait_ev(0, n);
        // Done edge: write lands and read data is taken here
        @(posedge clock);
        rdata = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        // Config write without the stoppable option keeps the watchdog on low speed
        if (w && be[0] && a == 4'h4) e_cfg = d[0] ? int'(d[2:0]) : int'({d[2], 2'h2});
        if (w && be[0] && a == 4'h0) e_stop = int'(d[0]);
        if (!w) chk("readdata", model(a), rdata);
    endtask
    task automatic rst_seq();
        int n;
        @(posedge clock);
        rst_b <= 1'h0;
        repeat (12) @(posedge clock);
        rst_b <= 1'h1;
        e_cfg = 2;
        e_stop = 0;
        wait_ev(2, n);
        chk("reset_delay", 1, n >= OPT + 1 && n <= OPT + 2);
        chk("run_after_reset", 2'h2, {cpu_clk_en, port_latch_hold});
    endtask
    task automatic halt();
        @(posedge clock);
        halt_exec <= 1'h1;
        raise <= 1'h0;
        @(posedge clock);
        halt_exec <= 1'h0;
    endtask
    task automatic wake(input logic acc, input logic pre, input logic masked);
        int n, idx;
        logic [7:0] m;
        idx = int'(rnd() % 8);
        m = 8'(rnd());
        m[idx] = masked;
        @(posedge clock);
        interrupt_mask_flag <= m;
        global_interrupt_accept_flag <= acc;
        line_sel <= 8'(idx);
        raise <= pre;
        halt();
        if (!pre || masked) begin
            @(negedge clock);
            chk("asleep", {3'h3, (e_cfg & 2) != 0 && lso_e()},
                {cpu_clk_en, port_latch_hold, periph_clk_en, watchdog_run});
            @(posedge clock);
            raise <= 1'h1;
            @(posedge clock);
            raise <= 1'h0;
            if (masked) begin
                repeat (20) @(posedge clock);
                chk("masked_asleep", 0, cpu_clk_en);
                m[idx] = 1'h0;
                interrupt_mask_flag <= m;
            end
            wait_ev(3, n);
        end
        wait_ev(1, n);
        chk("wake_delay", acc ? 12 : 4, n);
        chk("wake_kind", {acc, !acc, 2'h2},
            {vector_start, next_instr_start, cpu_clk_en, port_latch_hold});
        @(posedge clock);
        clear <= 1'h1;
        @(posedge clock);
        clear <= 1'h0;
    endtask
    initial begin
        rst_seq();
        for (int a = 0; a < 16; a += 4) bus(1'h0, 4'(a), 32'h0, 4'hF);
        bus(1'h1, 4'h8, 32'hFF, 4'hF);
        bus(1'h1, 4'h4, 32'h0, 4'hF);
        bus(1'h1, 4'h4, 32'h5, 4'h0);
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        bus(1'h0, 4'h8, 32'h0, 4'hF);
        $display("Test registers done");
        for (int i = 0; i < 16; i++) begin
            if (i == 8) begin
                bus(1'h1, 4'h4, 32'h5, 4'hF);
                bus(1'h1, 4'h0, 32'h1, 4'hF);
                bus(1'h0, 4'h8, 32'h0, 4'hF);
                @(negedge clock);
                chk("osc_timer", {lso_e(), (e_cfg & 4) == 0 || lso_e()},
                    {low_speed_osc_run, second_8bit_timer_run});
            end
            if (i == 12) bus(1'h1, 4'h4, 32'h3, 4'hF);
            wake(1'(rnd()), i % 3 == 0, i % 4 == 1);
        end
        $display("Test wake done");
        halt();
        rst_seq();
        bus(1'h0, 4'h4, 32'h0, 4'hF);
        $display("Test reset in halt done");
        results();
    end
endmodule // tb_halt_standby_control
